// >>> cfr_core.sv
// Purpose: Core registers, program counter, context flags and return stack
// Assumes: One flow request class wins per cycle by fixed priority
// Notes:   Relative branch offset is two's complement, sign extended

module cfr_core #(
	parameter int unsigned IP_W     = cfr_pkg::IP_W,
	parameter int unsigned DATA_W   = cfr_pkg::DATA_W,
	parameter int unsigned LVLS     = cfr_pkg::STACK_LVLS,
	parameter int unsigned DEPTH_W  = cfr_pkg::DEPTH_W
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Data-space access
	input  wire logic [7:0]          ds_addr,
	input  wire logic                ds_wr,
	input  wire logic                ds_rd,
	input  wire logic [DATA_W-1:0]   ds_wdata,
	output logic      [DATA_W-1:0]   ds_rdata,
	output logic                     ds_hit,
	// Sum register load from the ALU
	input  wire logic                sum_load,
	input  wire logic [DATA_W-1:0]   sum_value,
	// Program flow requests
	input  wire logic                step,
	input  wire logic                jump_instr,
	input  wire logic                subroutine_invoke,
	input  wire logic [IP_W-1:0]     target_addr,
	input  wire logic                branch,
	input  wire logic [DATA_W-1:0]   branch_offset,
	input  wire logic                irq_take,
	input  wire logic [IP_W-1:0]     irq_vector,
	input  wire logic                nmi_take,
	input  wire logic [IP_W-1:0]     nmi_vector,
	input  wire logic                sub_exit,
	input  wire logic                irq_exit,
	// Flag updates in the active context
	input  wire logic                arith_upd,
	input  wire logic                arith_carry,
	input  wire logic                logic_upd,
	input  wire logic                result_zero,
	input  wire logic                bit_test,
	input  wire logic                tested_bit,
	// Status
	output logic      [IP_W-1:0]     instruction_pointer,
	output logic                     active_carry,
	output logic                     active_zero,
	output logic      [1:0]          context_code,
	output logic      [DEPTH_W-1:0]  stack_depth,
	output logic      [DATA_W-1:0]   pointer_one_out,
	output logic      [DATA_W-1:0]   pointer_two_out
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (IP_W < 2 || IP_W > 16) begin : g_bad_ip
		$error("cfr_core: IP_W out of range");
	end
	if (DATA_W < 2 || DATA_W >= IP_W) begin : g_bad_data
		$error("cfr_core: DATA_W must stay below IP_W for the offset extension");
	end
	if (LVLS < 2 || LVLS >= (1 << DEPTH_W)) begin : g_bad_lvls
		$error("cfr_core: LVLS must be at least 2 and fit DEPTH_W");
	end

	// ----------------------------------------------------------------
	// Data-space registers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] sum_q;
	logic [DATA_W-1:0] ptr_one_q;
	logic [DATA_W-1:0] ptr_two_q;
	logic [DATA_W-1:0] sd_one_q;
	logic [DATA_W-1:0] sd_sec_q;
	logic [DATA_W-1:0] rdata_q;
	logic              hit_q;

	// Address decode
	wire sel_sum     = (ds_addr == cfr_pkg::ADDR_SUM);
	wire sel_ptr_one = (ds_addr == cfr_pkg::ADDR_PTR_ONE);
	wire sel_ptr_two = (ds_addr == cfr_pkg::ADDR_PTR_TWO);
	wire sel_sd_one  = (ds_addr == cfr_pkg::ADDR_SD_ONE);
	wire sel_sd_sec  = (ds_addr == cfr_pkg::ADDR_SD_SEC);
	wire sel_any     = sel_sum | sel_ptr_one | sel_ptr_two | sel_sd_one | sel_sd_sec;

	// Read mux; unmapped addresses read zero and drop the hit flag
	wire [DATA_W-1:0] rd_mux =
		sel_sum     ? sum_q     :
		sel_ptr_one ? ptr_one_q :
		sel_ptr_two ? ptr_two_q :
		sel_sd_one  ? sd_one_q  :
		sel_sd_sec  ? sd_sec_q  : '0;

	// A bus write to the sum register wins over an ALU load that cycle
	wire [DATA_W-1:0] sum_d = (ds_wr && sel_sum) ? ds_wdata :
	                          sum_load           ? sum_value : sum_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sum_q <= cfr_pkg::REG_RST;
		end else begin
			sum_q <= sum_d;
		end
	end

	// Pointer and short direct registers, written like any data location
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_one_q <= cfr_pkg::REG_RST;
			ptr_two_q <= cfr_pkg::REG_RST;
			sd_one_q  <= cfr_pkg::REG_RST;
			sd_sec_q  <= cfr_pkg::REG_RST;
		end else if (ds_wr) begin
			if (sel_ptr_one) ptr_one_q <= ds_wdata;
			if (sel_ptr_two) ptr_two_q <= ds_wdata;
			if (sel_sd_one)  sd_one_q  <= ds_wdata;
			if (sel_sd_sec)  sd_sec_q  <= ds_wdata;
		end
	end

	// Registered read answer, one cycle after the read strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= '0;
			hit_q   <= 1'b0;
		end else if (ds_rd) begin
			rdata_q <= rd_mux;
			hit_q   <= sel_any;
		end
	end

	// Read answer and pointer taps come straight from registers
	assign ds_rdata        = rdata_q;
	assign ds_hit          = hit_q;
	assign pointer_one_out = ptr_one_q;
	assign pointer_two_out = ptr_two_q;

	// ----------------------------------------------------------------
	// Return stack
	// ----------------------------------------------------------------
	cfr_stack_if #(.IP_W(IP_W), .DEPTH_W(DEPTH_W)) sif ();

	cfr_ret_stack #(
		.IP_W    (IP_W),
		.LVLS    (LVLS),
		.DEPTH_W (DEPTH_W)
	) u_stack (
		.clk     (clk),
		.reset_n (reset_n),
		.sif     (sif)
	);

	// ----------------------------------------------------------------
	// Flow priority: nmi, irq, call, jump, branch, return, step
	// ----------------------------------------------------------------
	logic [IP_W-1:0] ip_q;
	logic [IP_W-1:0] ip_d;

	// At most one class acts per cycle, so push and pop never meet
	wire do_nmi    = nmi_take;
	wire do_irq    = irq_take & ~do_nmi;
	wire do_call   = subroutine_invoke & ~nmi_take & ~irq_take;
	wire do_jump   = jump_instr & ~nmi_take & ~irq_take & ~subroutine_invoke;
	wire any_hi    = nmi_take | irq_take | subroutine_invoke | jump_instr;
	wire do_branch = branch & ~any_hi;
	wire any_ret   = sub_exit | irq_exit;
	wire do_ret    = any_ret & ~any_hi & ~branch;
	wire do_step   = step & ~any_hi & ~branch & ~any_ret;

	// Branch adder: pointer plus sign extended offset
	wire [IP_W-1:0] offs_ext = {{(IP_W-DATA_W){branch_offset[DATA_W-1]}}, branch_offset};
	wire [IP_W-1:0] ip_sum   = ip_q + offs_ext;
	wire [IP_W-1:0] ip_inc   = ip_q + 1'b1;

	// Return on an empty stack falls through to the next instruction
	wire [IP_W-1:0] ret_addr = sif.empty ? ip_inc : sif.top_addr;

	assign ip_d =
		do_nmi    ? nmi_vector  :
		do_irq    ? irq_vector  :
		do_call   ? target_addr :
		do_jump   ? target_addr :
		do_branch ? ip_sum      :
		do_ret    ? ret_addr    :
		do_step   ? ip_inc      : ip_q;

	// Current pointer enters the first level on call or interrupt
	assign sif.push      = do_nmi | do_irq | do_call;
	assign sif.pop       = do_ret;
	assign sif.push_addr = ip_q;

	// Reset loads the reset vector location
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ip_q <= IP_W'(cfr_pkg::RESET_VECTOR);
		end else begin
			ip_q <= ip_d;
		end
	end

	// Pointer and depth outputs leave flip-flops directly

	assign instruction_pointer = ip_q;
	assign stack_depth         = sif.depth;

	// ----------------------------------------------------------------
	// Execution context with one saved predecessor for the nmi level only
	// ----------------------------------------------------------------
	cfr_pkg::cfr_ctx_e ctx_q;
	cfr_pkg::cfr_ctx_e ctx_d;
	cfr_pkg::cfr_ctx_e nmi_prev_q;
	cfr_pkg::cfr_ctx_e nmi_prev_d;
	wire               ret_irq = do_ret & irq_exit;

	// Nmi entry from normal or irq remembers which pair was active before it
	always_comb begin
		ctx_d      = ctx_q;
		nmi_prev_d = nmi_prev_q;
		if (do_nmi) begin
			ctx_d      = cfr_pkg::CTX_NMI;
			nmi_prev_d = (ctx_q == cfr_pkg::CTX_NMI) ? nmi_prev_q : ctx_q;
			// A maskable request inside any interrupt keeps the context
		end else if (do_irq && ctx_q == cfr_pkg::CTX_NORMAL) begin
			ctx_d = cfr_pkg::CTX_IRQ;
		end else if (ret_irq) begin
			unique case (ctx_q)
				cfr_pkg::CTX_NMI: ctx_d = nmi_prev_q;
				cfr_pkg::CTX_IRQ: ctx_d = cfr_pkg::CTX_NORMAL;
				cfr_pkg::CTX_NORMAL: ctx_d = cfr_pkg::CTX_NORMAL;
				default: ctx_d = cfr_pkg::CTX_NMI;
			endcase
		end
	end

	// Reset selects the non-maskable context first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctx_q      <= cfr_pkg::CTX_NMI;
			nmi_prev_q <= cfr_pkg::CTX_NORMAL;
		end else begin
			ctx_q      <= ctx_d;
			nmi_prev_q <= nmi_prev_d;
		end
	end

	// Code is the enum value itself: 00 normal, 01 irq, 11 nmi
	assign context_code = ctx_q;

	// ----------------------------------------------------------------
	// Three carry/zero pairs; only the active pair is ever written
	// ----------------------------------------------------------------
	localparam cfr_pkg::cfr_ctx_e CTX_OF [3] = '{cfr_pkg::CTX_NORMAL,
	                                            cfr_pkg::CTX_IRQ,
	                                            cfr_pkg::CTX_NMI};
	wire [2:0] carry_v;  // One carry per context, normal first
	wire [2:0] zero_v;

	// Bit test takes priority over an arithmetic carry in the same cycle
	wire c_upd = bit_test | arith_upd;
	wire c_val = bit_test ? tested_bit : arith_carry;
	wire z_upd = arith_upd | logic_upd;

	// Each pair lives in its own flip-flops so no vector has two writers
	for (genvar k = 0; k < 3; k++) begin : g_pair
		wire  own = (ctx_q == CTX_OF[k]);
		logic c_q;
		logic z_q;
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				c_q <= 1'b0;
				z_q <= 1'b0;
			end else begin
				if (own && c_upd) c_q <= c_val;
				if (own && z_upd) z_q <= result_zero;
			end
		end
		assign carry_v[k] = c_q;
		assign zero_v[k]  = z_q;
	end

	// Active pair follows the context and drives the carry and zero outputs
	wire [1:0] act_idx = (ctx_q == cfr_pkg::CTX_NORMAL) ? 2'h0 :
	                     (ctx_q == cfr_pkg::CTX_IRQ)    ? 2'h1 : 2'h2;
	assign active_carry = carry_v[act_idx];
	assign active_zero  = zero_v[act_idx];

endmodule : cfr_core

// >>> cfr_pkg.sv
// Purpose: Shared constants and types for the core register and flow unit
// Assumes: One machine-cycle clock drives the whole unit
// Notes:   Vector values are locations in program space, not their contents
package cfr_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int unsigned IP_W        = 12;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned STACK_LVLS  = 6;
	localparam int unsigned DEPTH_W     = 3;

	// ----------------------------------------------------------------
	// Data-space offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PTR_ONE  = 8'h80;
	localparam logic [7:0] ADDR_PTR_TWO  = 8'h81;
	localparam logic [7:0] ADDR_SD_ONE   = 8'h82;
	localparam logic [7:0] ADDR_SD_SEC   = 8'h83;
	localparam logic [7:0] ADDR_SUM      = 8'hFF;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_RST      = 8'h00;
	localparam logic [11:0] RESET_VECTOR = 12'hFFE;
	localparam logic [11:0] IP_RST       = 12'h000;
	localparam logic [2:0]  DEPTH_RST    = 3'h0;

	// ----------------------------------------------------------------
	// Execution contexts, Gray coded along normal -> irq -> nmi
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CTX_NORMAL = 2'h0,
		CTX_IRQ    = 2'h1,
		CTX_NMI    = 2'h3
	} cfr_ctx_e;

endpackage : cfr_pkg

// >>> cfr_stack_if.sv
// Purpose: Carrier between the flow unit and its return stack
// Assumes: Push and pop are never raised in the same cycle
// Notes:   Depth saturates inside the stack module
interface cfr_stack_if #(
	parameter int unsigned IP_W    = 12,
	parameter int unsigned DEPTH_W = 3
);
	logic               push;
	logic               pop;
	logic [IP_W-1:0]    push_addr;
	logic [IP_W-1:0]    top_addr;
	logic [DEPTH_W-1:0] depth;
	logic               empty;
	logic               full;

	modport core  (output push, pop, push_addr, input top_addr, depth, empty, full);
	modport stack (input push, pop, push_addr, output top_addr, depth, empty, full);
endinterface : cfr_stack_if

// >>> cfr_ret_stack.sv
// Purpose: Six-level hardware return stack with a saturating fill count
// Assumes: Caller never pushes and pops in the same cycle
// Notes:   Levels are registers, so the top address leaves a flip-flop
module cfr_ret_stack #(
	parameter int unsigned IP_W    = 12,
	parameter int unsigned LVLS    = 6,
	parameter int unsigned DEPTH_W = 3
) (
	input  wire logic clk,
	input  wire logic reset_n,
	cfr_stack_if.stack sif
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (LVLS < 2 || LVLS >= (1 << DEPTH_W)) begin : g_bad_depth
		$error("cfr_ret_stack: LVLS must be at least 2 and fit DEPTH_W");
	end

	logic [IP_W-1:0]    lvl_q [LVLS];
	logic [DEPTH_W-1:0] depth_q;
	logic [DEPTH_W-1:0] depth_d;

	// ----------------------------------------------------------------
	// Level shift: push moves down, oldest falls off the bottom
	// ----------------------------------------------------------------
	for (genvar i = 0; i < LVLS; i++) begin : g_lvl
		logic [IP_W-1:0] below;
		logic [IP_W-1:0] above;
		if (i == LVLS - 1) begin : g_last
			assign below = lvl_q[i];  // Bottom keeps its value on pop
		end else begin : g_mid
			assign below = lvl_q[i+1];
		end
		if (i == 0) begin : g_first
			assign above = sif.push_addr;
		end else begin : g_rest
			assign above = lvl_q[i-1];
		end
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				lvl_q[i] <= {IP_W{1'b0}};
			end else if (sif.push) begin
				lvl_q[i] <= above;
			end else if (sif.pop && !sif.empty) begin
				lvl_q[i] <= below;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fill count saturates at zero and at the level count
	// ----------------------------------------------------------------
	assign sif.full  = (depth_q == DEPTH_W'(LVLS));
	assign sif.empty = (depth_q == '0);
	assign depth_d   = (sif.push && !sif.full)  ? depth_q + 1'b1 :
	                   (sif.pop  && !sif.empty) ? depth_q - 1'b1 : depth_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			depth_q <= '0;
		end else begin
			depth_q <= depth_d;
		end
	end

	assign sif.top_addr = lvl_q[0];
	assign sif.depth    = depth_q;

endmodule : cfr_ret_stack

// >>> cfr_checker.sv
// Purpose: Port-level checks for the register and flow unit
// Assumes: Sees only the top module ports; one clock domain
// Notes:   Flow priority is nmi, irq, call, jump, branch, return, step
module cfr_checker (
	input logic        clk,
	input logic        reset_n,
	input logic [7:0]  ds_addr,
	input logic        ds_rd,
	input logic        ds_hit,
	input logic        step,
	input logic        jump_instr,
	input logic        subroutine_invoke,
	input logic [11:0] target_addr,
	input logic        branch,
	input logic [7:0]  branch_offset,
	input logic        irq_take,
	input logic        nmi_take,
	input logic [11:0] nmi_vector,
	input logic        sub_exit,
	input logic        irq_exit,
	input logic        arith_upd,
	input logic        arith_carry,
	input logic        result_zero,
	input logic        bit_test,
	input logic [11:0] instruction_pointer,
	input logic        active_carry,
	input logic        active_zero,
	input logic [1:0]  context_code,
	input logic [2:0]  stack_depth
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Request classes that outrank a given flow request
	// ----------------------------------------------------------------
	wire hi_irq = nmi_take | irq_take;
	wire hi_br  = hi_irq | subroutine_invoke | jump_instr;
	wire hi_ret = hi_br | branch;
	wire any_f  = hi_ret | sub_exit | irq_exit;
	wire ctx_sw = hi_irq | irq_exit; // Context may move, so flags may too
	wire mapped = ds_addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_STEP: assert property (step && !any_f |=>
		instruction_pointer == $past(instruction_pointer) + 12'h001) else $error("no advance");
	AST_JUMP: assert property (jump_instr && !hi_irq && !subroutine_invoke |=>
		instruction_pointer == $past(target_addr)) else $error("jump target missed");
	AST_BRANCH: assert property (branch && !hi_br |=> instruction_pointer ==
		$past(instruction_pointer) + {{4{$past(branch_offset[7])}}, $past(branch_offset)})
		else $error("branch sum wrong");
	AST_CALL: assert property (subroutine_invoke && !hi_irq |=> stack_depth ==
		(($past(stack_depth) == 3'h6) ? 3'h6 : $past(stack_depth) + 3'h1)) else $error("push depth");
	AST_POP: assert property (sub_exit && !hi_ret && stack_depth != 3'h0 |=>
		stack_depth == $past(stack_depth) - 3'h1) else $error("pop depth");
	AST_EMPTY_RET: assert property (sub_exit && !hi_ret && stack_depth == 3'h0 |=>
		stack_depth == 3'h0 && instruction_pointer == $past(instruction_pointer) + 12'h001)
		else $error("empty return wrong");
	AST_NMI: assert property (nmi_take |=> context_code == 2'h3 &&
		instruction_pointer == $past(nmi_vector)) else $error("nmi entry wrong");
	AST_HOLD: assert property (!arith_upd && !bit_test && !ctx_sw |=>
		$stable(active_carry)) else $error("carry changed without cause");
	AST_ARITH: assert property (arith_upd && !bit_test && !ctx_sw |=>
		active_carry == $past(arith_carry) && active_zero == $past(result_zero))
		else $error("flags not from result");
	AST_HIT: assert property (ds_rd |=> ds_hit == $past(mapped)) else $error("hit wrong");
endmodule : cfr_checker

// >>> core_flow_registers_test.sv
// Purpose: Directed bench for the register and flow unit
// Assumes: Inputs change on the falling edge only
// Notes:   Flow ops: 1 step 2 jump 3 call 4 branch 5 irq 6 nmi 7 ret 8 irq ret
module core_flow_registers_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  ds_addr = 8'h00;
	logic        ds_wr = 1'b0;
	logic        ds_rd = 1'b0;
	logic [7:0]  ds_wdata = 8'h00;
	logic        sum_load = 1'b0;
	logic [7:0]  sum_value = 8'h00;
	logic [7:0]  fl_req = 8'h00;
	logic [5:0]  fv = 6'h00;
	logic [11:0] fa = 12'h000;
	logic        step, jump_instr, subroutine_invoke, branch, irq_take, nmi_take;
	logic        sub_exit, irq_exit, arith_upd, arith_carry, logic_upd, result_zero;
	logic        bit_test, tested_bit, ds_hit, active_carry, active_zero;
	logic [11:0] target_addr, irq_vector, nmi_vector, instruction_pointer;
	logic [7:0]  branch_offset, ds_rdata, pointer_one_out, pointer_two_out;
	logic [1:0]  context_code;
	logic [2:0]  stack_depth;
	logic [7:0]  adr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          i;
	// One-hot flow request vector and packed flag vector fan out to the ports
	assign {irq_exit, sub_exit, nmi_take, irq_take, branch, subroutine_invoke, jump_instr,
		step} = fl_req;
	assign {arith_upd, arith_carry, logic_upd, result_zero, bit_test, tested_bit} = fv;
	assign target_addr   = fa;
	assign irq_vector    = fa;
	assign nmi_vector    = fa;
	assign branch_offset = fa[7:0];
	always #20 clk = ~clk;
	cfr_core DUT (.*);
	// ----------------------------------------------------------------
	// Bus, flow and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic drv(input logic [3:0] op, input logic [11:0] a, input logic [5:0] f);
		@(negedge clk);
		fl_req = (op == 4'h0) ? 8'h00 : 8'(8'h01 << (op - 4'h1));
		fa = a;
		fv = f;
	endtask : drv
	// Idle cycle after the request lets its edge land before any check
	task automatic op1(input logic [3:0] op, input logic [11:0] a, input logic [5:0] f);
		drv(op, a, f);
		drv(4'h0, 12'h000, 6'h00);
	endtask : op1
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		ds_addr = a;
		ds_wdata = d;
		ds_wr = 1'b1;
		@(negedge clk);
		ds_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
		@(negedge clk);
		ds_addr = a;
		ds_rd = 1'b1;
		@(negedge clk);
		ds_rd = 1'b0;
		chk({4'h0, ds_rdata}, {4'h0, d});
		chk({11'h0, ds_hit}, {11'h0, h});
	endtask : rd
	task automatic finish_test;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		chk(instruction_pointer, 12'hFFE);
		chk({10'h0, context_code}, 12'h003);
		for (i = 0; i < 5; i++) wr(adr[i], 8'(8'h11 * (i + 1)));
		wr(8'h84, 8'h5A);
		for (i = 0; i < 5; i++) rd(adr[i], 8'(8'h11 * (i + 1)), 1'b1);
		rd(8'h84, 8'h00, 1'b0);
		chk({pointer_two_out, pointer_one_out[3:0]}, 12'h221);
		@(negedge clk);
		sum_load = 1'b1;
		sum_value = 8'hA5;
		@(negedge clk);
		sum_load = 1'b0;
		rd(8'hFF, 8'hA5, 1'b1);
		op1(4'h0, 12'h000, 6'b110000);
		chk({10'h0, active_carry, active_zero}, 12'h002);
		op1(4'h0, 12'h000, 6'b000010);
		chk({10'h0, active_carry, active_zero}, 12'h000);
		op1(4'h0, 12'h000, 6'b001100);
		chk({10'h0, active_carry, active_zero}, 12'h001);
		op1(4'h8, 12'h000, 6'h00);
		chk(instruction_pointer, 12'hFFF);
		chk({8'h0, context_code, active_carry, active_zero}, 12'h000);
		op1(4'h0, 12'h000, 6'b110100);
		op1(4'h1, 12'h000, 6'h00);
		chk(instruction_pointer, 12'h000);
		op1(4'h2, 12'h123, 6'h00);
		chk(instruction_pointer, 12'h123);
		op1(4'h4, 12'h0F0, 6'h00);
		chk(instruction_pointer, 12'h113);
		op1(4'h4, 12'h07F, 6'h00);
		chk(instruction_pointer, 12'h192);
		op1(4'h5, 12'hFF0, 6'h00);
		chk({context_code, stack_depth, instruction_pointer[5:0], active_carry}, 12'h4E0);
		op1(4'h0, 12'h000, 6'b110000);
		op1(4'h6, 12'hFFC, 6'h00);
		chk({context_code, stack_depth, active_carry, active_zero}, 12'h069);
		chk(instruction_pointer, 12'hFFC);
		op1(4'h8, 12'h000, 6'h00);
		chk({context_code, stack_depth, active_carry, active_zero}, 12'h026);
		chk(instruction_pointer, 12'hFF0);
		op1(4'h8, 12'h000, 6'h00);
		chk({context_code, stack_depth, active_carry, active_zero}, 12'h003);
		chk(instruction_pointer, 12'h192);
		for (i = 0; i < 7; i++) drv(4'h3, 12'(12'h100 + i), 6'h00);
		drv(4'h0, 12'h000, 6'h00);
		chk({9'h0, stack_depth}, 12'h006);
		chk(instruction_pointer, 12'h106);
		for (i = 0; i < 6; i++) begin
			op1(4'h7, 12'h000, 6'h00);
			chk(instruction_pointer, 12'(12'h105 - i));
		end
		op1(4'h7, 12'h000, 6'h00);
		chk({9'h0, stack_depth}, 12'h000);
		chk(instruction_pointer, 12'h101);
		// Mid-run reset must restore the vector, nmi context and empty stack
		@(negedge clk);
		reset_n = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		chk(instruction_pointer, 12'hFFE);
		chk({5'h0, context_code, stack_depth, active_carry, active_zero}, 12'h060);
		rd(8'h80, 8'h00, 1'b1);
		finish_test();
	end
	// Hang guard: a stuck run counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule : core_flow_registers_test

bind cfr_core cfr_checker u_chk (.*);
